// ### sbocd_top.sv
// Function
// - In secure boot mode the block fetches otp bytes 0 and 1 and applies the settings they hold.
// - Byte 0 bit 0 set blocks the external debug and trace port, clear leaves it open.
// - Byte 0 bit 1 set enables secure-world partitioning, clear leaves it off.
// - Byte 1 bit 0 is inverted: zero enables debug mode, one disables it.
// - Byte 1 bit 1 set turns boot code authentication on, clear turns it off.
// - Byte 1 bits 3:2 give the key size: 00 none, 01 1K, 10 2K, 11 4K.
// - Byte 1 bit 4 clear means full key stored, set means only a SHA-256 hash is stored.
// - 24 MHz reference needs straps 5 and 7 high and 9:8 at 3; 48 MHz needs 5 and 7 low and 9:8 at 3.
// - The boot loader works with the system pll enabled or bypassed, per the clock option strap.
// - With debug mode enabled, secure boot enable comes from extended boot option bit 17.
`timescale 1ns/1ps
`default_nettype none
module sbocd_top
	import sbocd_pkg::*;
(
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// board straps and fuse level
	input  wire logic [STRAP_W-1:0]  bootstrapStrapPins,
	input  wire logic                secBootFuse,
	// otp memory
	output logic                     otpReq,
	output logic      [OTP_AW-1:0]   otpAddr,
	input  wire logic                otpAck,
	input  wire logic [7:0]          otpData,
	// decoded security and clock settings
	output logic                     cfgDone,
	output logic                     secBootActive,
	output logic                     dbgPortBlock,
	output logic                     secWorldEn,
	output logic                     dbgModeEn,
	output logic                     authEn,
	output logic      [1:0]          keySize,
	output logic                     keyHashOnly,
	output logic                     pllEnable,
	output logic                     ref24Sel,
	output logic                     ref48Sel,
	output logic                     clkCfgErr,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [APB_AW-1:0]   paddr,
	input  wire logic [31:0]         pwdata,
	output logic                     pready,
	output logic      [31:0]         prdata,
	output logic                     pslverr
);

	// ==========================================
	// synchronisers
	logic [STRAP_W-1:0] strapSync;
	logic               fuseSync;

	sbocd_sync #(
		.W (STRAP_W + 1)
	) u_sync (
		.clk     (clk),
		.rst_n   (rst_n),
		.asyncIn ({secBootFuse, bootstrapStrapPins}),
		.syncOut ({fuseSync, strapSync})
	);

	// ==========================================
	// capture sequencer
	sbocd_state_t       state_q,     state_d;
	logic [SETTLE_W-1:0] settle_q,   settle_d;
	logic [STRAP_W-1:0] strapCap_q,  strapCap_d;
	logic               fuseCap_q,   fuseCap_d;
	logic [7:0]         byte0_q,     byte0_d;
	logic [7:0]         byte1_q,     byte1_d;
	logic               otpReq_q,    otpReq_d;
	logic [OTP_AW-1:0]  otpAddr_q,   otpAddr_d;
	logic               done_q,      done_d;
	logic               secAct_q,    secAct_d;
	logic               dbgBlk_q,    dbgBlk_d;
	logic               secWld_q,    secWld_d;
	logic               dbgEn_q,     dbgEn_d;
	logic               auth_q,      auth_d;
	logic [1:0]         key_q,       key_d;
	logic               hash_q,      hash_d;
	logic               pll_q,       pll_d;
	logic               ref24_q,     ref24_d;
	logic               ref48_q,     ref48_d;
	logic               clkErr_q,    clkErr_d;
	logic               forceBlk_q;
	logic               fuseDbgEn;
	logic               selXtal;

	always_comb begin
		state_d    = state_q;
		settle_d   = settle_q;
		strapCap_d = strapCap_q;
		fuseCap_d  = fuseCap_q;
		byte0_d    = byte0_q;
		byte1_d    = byte1_q;
		otpReq_d   = otpReq_q;
		otpAddr_d  = otpAddr_q;
		done_d     = done_q;
		secAct_d   = secAct_q;
		dbgBlk_d   = dbgBlk_q;
		secWld_d   = secWld_q;
		dbgEn_d    = dbgEn_q;
		auth_d     = auth_q;
		key_d      = key_q;
		hash_d     = hash_q;
		pll_d      = pll_q;
		ref24_d    = ref24_q;
		ref48_d    = ref48_q;
		clkErr_d   = clkErr_q;
		fuseDbgEn  = ~byte1_q[B1_DBG_DIS];
		selXtal    = (strapCap_q[SP_PLLSEL_LSB +: 2] == PLLSEL_XTAL);
		unique case (state_q)
			S_SETTLE: begin
				// straps are trusted only once the synchroniser has filled after reset
				if (settle_q == SETTLE_W'(SETTLE_CYC - 1)) begin
					strapCap_d = strapSync;
					fuseCap_d  = fuseSync;
					otpReq_d   = 1'b1;
					otpAddr_d  = OTP_BYTE0_ADDR;
					state_d    = S_RD0;
				end else begin
					settle_d = settle_q + SETTLE_W'(1);
				end
			end
			S_RD0: begin
				if (otpAck) begin
					byte0_d   = otpData;
					otpAddr_d = OTP_BYTE1_ADDR;
					state_d   = S_RD1;
				end
			end
			S_RD1: begin
				if (otpAck) begin
					byte1_d  = otpData;
					otpReq_d = 1'b0;
					state_d  = S_APPLY;
				end
			end
			S_APPLY: begin
				secAct_d = fuseDbgEn ? strapCap_q[SP_SEC_BOOT] : fuseCap_q;
				if (secAct_d) begin
					dbgBlk_d = byte0_q[B0_DBG_BLOCK];
					secWld_d = byte0_q[B0_SEC_WORLD];
					dbgEn_d  = fuseDbgEn;
					auth_d   = byte1_q[B1_AUTH];
				end else begin
					dbgBlk_d = 1'b0;
					secWld_d = 1'b0;
					dbgEn_d  = 1'b1;
					auth_d   = 1'b0;
				end
				// key fields only mean something when authentication runs
				key_d    = auth_d ? byte1_q[B1_KEY_LSB +: 2] : KEY_NA;
				hash_d   = auth_d & byte1_q[B1_KEY_PKG];
				pll_d    = strapCap_q[SP_PLL_EN];
				ref24_d  = selXtal & strapCap_q[SP_REF_SPARE]
					& strapCap_q[SP_REF_FREQ];
				ref48_d  = selXtal & ~strapCap_q[SP_REF_SPARE]
					& ~strapCap_q[SP_REF_FREQ];
				// a mismatched spare strap or wrong select shows as a config error
				clkErr_d = ~(ref24_d | ref48_d);
				done_d   = 1'b1;
				state_d  = S_DONE;
			end
			S_DONE: begin
				state_d = S_DONE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q    <= S_SETTLE;
			settle_q   <= '0;
			strapCap_q <= '0;
			fuseCap_q  <= 1'b0;
			byte0_q    <= '0;
			byte1_q    <= '0;
			otpReq_q   <= 1'b0;
			otpAddr_q  <= OTP_BYTE0_ADDR;
			done_q     <= 1'b0;
			secAct_q   <= 1'b0;
			// the port stays blocked until the fuses have been read
			dbgBlk_q   <= 1'b1;
			secWld_q   <= 1'b0;
			dbgEn_q    <= 1'b0;
			auth_q     <= 1'b0;
			key_q      <= KEY_NA;
			hash_q     <= 1'b0;
			pll_q      <= 1'b0;
			ref24_q    <= 1'b0;
			ref48_q    <= 1'b0;
			clkErr_q   <= 1'b0;
		end else begin
			state_q    <= state_d;
			settle_q   <= settle_d;
			strapCap_q <= strapCap_d;
			fuseCap_q  <= fuseCap_d;
			byte0_q    <= byte0_d;
			byte1_q    <= byte1_d;
			otpReq_q   <= otpReq_d;
			otpAddr_q  <= otpAddr_d;
			done_q     <= done_d;
			secAct_q   <= secAct_d;
			dbgBlk_q   <= dbgBlk_d;
			secWld_q   <= secWld_d;
			dbgEn_q    <= dbgEn_d;
			auth_q     <= auth_d;
			key_q      <= key_d;
			hash_q     <= hash_d;
			pll_q      <= pll_d;
			ref24_q    <= ref24_d;
			ref48_q    <= ref48_d;
			clkErr_q   <= clkErr_d;
		end
	end

	// ==========================================
	// apb slave, one wait-free access phase
	logic        pready_q,  pready_d;
	logic [31:0] prdata_q,  prdata_d;
	logic        pslverr_q, pslverr_d;
	logic        forceBlk_d;
	logic [31:0] rdWord;
	logic        badAddr;

	always_comb begin
		rdWord  = '0;
		badAddr = 1'b0;
		unique case (paddr)
			ADDR_STATUS: begin
				rdWord[STS_DONE]              = done_q;
				rdWord[STS_SEC_ACT]           = secAct_q;
				rdWord[STS_CLK_ERR]           = clkErr_q;
				rdWord[STS_REF24]             = ref24_q;
				rdWord[STS_REF48]             = ref48_q;
				rdWord[STS_PLL_EN]            = pll_q;
				rdWord[STS_DBG_BLOCK]         = dbgBlk_q | forceBlk_q;
				rdWord[STS_SEC_WORLD]         = secWld_q;
				rdWord[STS_DBG_EN]            = dbgEn_q;
				rdWord[STS_AUTH]              = auth_q;
				rdWord[STS_KEY_LSB +: 2]      = key_q;
				rdWord[STS_KEY_HASH]          = hash_q;
			end
			ADDR_OTP: begin
				rdWord[7:0]                   = byte0_q;
				rdWord[OTP_B1_LSB +: 8]       = byte1_q;
			end
			ADDR_STRAP: begin
				rdWord[STRAP_W-1:0]           = strapCap_q;
			end
			ADDR_CTRL: begin
				rdWord[CTRL_FORCE_BLK]        = forceBlk_q;
			end
			default: begin
				badAddr = 1'b1;
			end
		endcase
		pready_d   = psel & ~penable;
		prdata_d   = (psel & ~penable & ~pwrite) ? rdWord : '0;
		pslverr_d  = psel & ~penable & badAddr;
		// software may only tighten the debug block, never loosen it before reset
		forceBlk_d = forceBlk_q
			| (psel & penable & pready_q & pwrite & (paddr == ADDR_CTRL)
			& pwdata[CTRL_FORCE_BLK]);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_q   <= 1'b0;
			prdata_q   <= '0;
			pslverr_q  <= 1'b0;
			forceBlk_q <= 1'b0;
		end else begin
			pready_q   <= pready_d;
			prdata_q   <= prdata_d;
			pslverr_q  <= pslverr_d;
			forceBlk_q <= forceBlk_d;
		end
	end

	// ==========================================
	// outputs
	logic dbgOut_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dbgOut_q <= 1'b1;
		end else begin
			dbgOut_q <= dbgBlk_d | forceBlk_d;
		end
	end

	assign otpReq        = otpReq_q;
	assign otpAddr       = otpAddr_q;
	assign cfgDone       = done_q;
	assign secBootActive = secAct_q;
	assign dbgPortBlock  = dbgOut_q;
	assign secWorldEn    = secWld_q;
	assign dbgModeEn     = dbgEn_q;
	assign authEn        = auth_q;
	assign keySize       = key_q;
	assign keyHashOnly   = hash_q;
	assign pllEnable     = pll_q;
	assign ref24Sel      = ref24_q;
	assign ref48Sel      = ref48_q;
	assign clkCfgErr     = clkErr_q;
	assign pready        = pready_q;
	assign prdata        = prdata_q;
	assign pslverr       = pslverr_q;

	// ==========================================
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_fetch_b1;
		otpReq_q && otpAck && (state_q == S_RD1) |=> (byte1_q == $past(otpData));
	endproperty
	a_fetch_b1: assert property (p_fetch_b1) else $error("otp byte 1 not captured");

	property p_dbg_block;
		$rose(done_q) && secAct_q |-> dbgOut_q == (byte0_q[B0_DBG_BLOCK] | forceBlk_q);
	endproperty
	a_dbg_block: assert property (p_dbg_block) else $error("debug port block wrong");

	property p_sec_world;
		$rose(done_q) |-> secWld_q == (secAct_q & byte0_q[B0_SEC_WORLD]);
	endproperty
	a_sec_world: assert property (p_sec_world) else $error("secure world enable wrong");

	property p_dbg_mode;
		$rose(done_q) && secAct_q |-> dbgEn_q == !byte1_q[B1_DBG_DIS];
	endproperty
	a_dbg_mode: assert property (p_dbg_mode) else $error("debug mode sense wrong");

	property p_auth_key;
		$rose(done_q) && secAct_q |-> auth_q == byte1_q[B1_AUTH]
			&& (!auth_q || (key_q == byte1_q[B1_KEY_LSB +: 2]
			&& hash_q == byte1_q[B1_KEY_PKG]));
	endproperty
	a_auth_key: assert property (p_auth_key) else $error("auth or key field wrong");

	property p_key_ignored;
		done_q && !auth_q |-> key_q == KEY_NA && !hash_q;
	endproperty
	a_key_ignored: assert property (p_key_ignored) else $error("key fields leak");

	property p_ref_clk;
		$rose(done_q) |-> ref24_q == (selXtal && strapCap_q[SP_REF_FREQ]
			&& strapCap_q[SP_REF_SPARE]) && clkErr_q == !(ref24_q || ref48_q);
	endproperty
	a_ref_clk: assert property (p_ref_clk) else $error("reference clock decode wrong");

	property p_pll;
		$rose(done_q) |-> pll_q == strapCap_q[SP_PLL_EN];
	endproperty
	a_pll: assert property (p_pll) else $error("pll option wrong");

	property p_sec_src;
		$rose(done_q) && !byte1_q[B1_DBG_DIS] |-> secAct_q == strapCap_q[SP_SEC_BOOT];
	endproperty
	a_sec_src: assert property (p_sec_src) else $error("secure boot source wrong");

	property p_hold;
		done_q |=> done_q && $stable(secAct_q) && $stable(secWld_q)
			&& $stable(auth_q) && $stable(key_q) [*4];
	endproperty
	a_hold: assert property (p_hold) else $error("settings changed after capture");

endmodule
`default_nettype wire

// ### sbocd_pkg.sv
`default_nettype none
package sbocd_pkg;

	// ==========================================
	// clock and timing
	localparam int CLK_PERIOD_NS = 25;
	// straps must have crossed the synchroniser before they are captured
	localparam int SETTLE_NS     = 100;
	localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W      = 3;

	// ==========================================
	// otp side
	localparam int             OTP_AW         = 8;
	localparam logic [OTP_AW-1:0] OTP_BYTE0_ADDR = 8'h00;
	localparam logic [OTP_AW-1:0] OTP_BYTE1_ADDR = 8'h01;
	localparam int B0_DBG_BLOCK  = 0;
	localparam int B0_SEC_WORLD  = 1;
	localparam int B1_DBG_DIS    = 0;
	localparam int B1_AUTH       = 1;
	localparam int B1_KEY_LSB    = 2;
	localparam int B1_KEY_PKG    = 4;
	localparam logic [1:0] KEY_NA = 2'h0;

	// ==========================================
	// bootstrap straps
	localparam int STRAP_W       = 22;
	localparam int SP_REF_SPARE  = 5;
	localparam int SP_REF_FREQ   = 7;
	localparam int SP_PLLSEL_LSB = 8;
	localparam int SP_SEC_BOOT   = 17;
	localparam int SP_PLL_EN     = 21;
	localparam logic [1:0] PLLSEL_XTAL = 2'h3;

	// ==========================================
	// apb register map
	localparam int              APB_AW      = 12;
	localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h000;
	localparam logic [APB_AW-1:0] ADDR_OTP    = 12'h004;
	localparam logic [APB_AW-1:0] ADDR_STRAP  = 12'h008;
	localparam logic [APB_AW-1:0] ADDR_CTRL   = 12'h00C;
	localparam int CTRL_FORCE_BLK = 0;
	localparam int STS_DONE       = 0;
	localparam int STS_SEC_ACT    = 1;
	localparam int STS_CLK_ERR    = 2;
	localparam int STS_REF24      = 3;
	localparam int STS_REF48      = 4;
	localparam int STS_PLL_EN     = 5;
	localparam int STS_DBG_BLOCK  = 8;
	localparam int STS_SEC_WORLD  = 9;
	localparam int STS_DBG_EN     = 10;
	localparam int STS_AUTH       = 11;
	localparam int STS_KEY_LSB    = 12;
	localparam int STS_KEY_HASH   = 14;
	localparam int OTP_B1_LSB     = 8;

	typedef enum logic [2:0] {
		S_SETTLE,
		S_RD0,
		S_RD1,
		S_APPLY,
		S_DONE
	} sbocd_state_t;

endpackage
`default_nettype wire

// ### sbocd_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sbocd_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// asynchronous in, synchronous out
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= asyncIn;
			sync_q <= meta_q;
		end
	end

	assign syncOut = sync_q;

endmodule
`default_nettype wire

// ### sbocd_otp_model.sv
`timescale 1ns/1ps
`default_nettype none
module sbocd_otp_model
	import sbocd_pkg::*;
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// otp port
	input  wire logic              otpReq,
	input  wire logic [OTP_AW-1:0] otpAddr,
	output logic                   otpAck,
	output logic      [7:0]        otpData,
	// fuse contents and answer delay
	input  wire logic [7:0]        byte0,
	input  wire logic [7:0]        byte1,
	input  wire logic [3:0]        ackDelay
);
	// ==========================================
	// read responder
	logic [3:0] waitQ;

	// data toggles outside the ack pulse so a stale byte never looks valid
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			otpAck  <= 1'b0;
			otpData <= 8'hA5;
			waitQ   <= 4'h0;
		end else if (otpAck) begin
			otpAck  <= 1'b0;
			otpData <= ~otpData;
			waitQ   <= 4'h0;
		end else if (otpReq && waitQ >= ackDelay) begin
			otpAck  <= 1'b1;
			otpData <= (otpAddr == OTP_BYTE1_ADDR) ? byte1 : byte0;
		end else begin
			otpData <= ~otpData;
			waitQ   <= otpReq ? waitQ + 4'h1 : 4'h0;
		end
	end
endmodule
`default_nettype wire

// ### sbocd_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
	import sbocd_pkg::*;
;
	// ==========================================
	// signals
	logic                clk     = 1'b0;
	logic                rst_n   = 1'b0;
	logic [STRAP_W-1:0]  straps  = '0;
	logic                fuse    = 1'b0;
	logic [7:0]          b0      = 8'h00;
	logic [7:0]          b1      = 8'h00;
	logic [3:0]          dly     = 4'h0;
	logic                psel    = 1'b0;
	logic                penable = 1'b0;
	logic                pwrite  = 1'b0;
	logic [APB_AW-1:0]   paddr   = '0;
	logic [31:0]         pwdata  = '0;
	logic                otpReq, otpAck, pready, pslverr, cfgDone, secBootActive;
	logic                dbgPortBlock, secWorldEn, dbgModeEn, authEn, keyHashOnly;
	logic                pllEnable, ref24Sel, ref48Sel, clkCfgErr;
	logic [1:0]          keySize;
	logic [OTP_AW-1:0]   otpAddr;
	logic [7:0]          otpData;
	logic [31:0]         prdata;
	logic [OTP_AW-1:0]   seenAddr[$];
	int                  n_errors = 0;
	int                  total_checks = 0;
	int                  cyc = 0;
	wire logic [12:0]    outv = {cfgDone, secBootActive, dbgPortBlock, secWorldEn, dbgModeEn,
		authEn, keySize, keyHashOnly, pllEnable, ref24Sel, ref48Sel, clkCfgErr};

	// boot cases: straps, fuse, byte 0, byte 1, otp answer delay
	localparam logic [21:0] S [6] = '{22'h2203A0, 22'h000300, 22'h0203A0, 22'h000320,
		22'h000100, 22'h2203A0};
	localparam logic        F [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
	localparam logic [7:0]  B0 [6] = '{8'h03, 8'h01, 8'h02, 8'h03, 8'h03, 8'h00};
	localparam logic [7:0]  B1 [6] = '{8'h06, 8'h1B, 8'h0E, 8'h1D, 8'h00, 8'h13};
	localparam logic [3:0]  D [6] = '{4'h0, 4'h3, 4'h1, 4'h2, 4'h0, 4'h5};

	sbocd_top sbocd_top_i (.clk(clk), .rst_n(rst_n), .bootstrapStrapPins(straps),
		.secBootFuse(fuse), .otpReq(otpReq), .otpAddr(otpAddr), .otpAck(otpAck),
		.otpData(otpData), .cfgDone(cfgDone), .secBootActive(secBootActive),
		.dbgPortBlock(dbgPortBlock), .secWorldEn(secWorldEn), .dbgModeEn(dbgModeEn),
		.authEn(authEn), .keySize(keySize), .keyHashOnly(keyHashOnly),
		.pllEnable(pllEnable), .ref24Sel(ref24Sel), .ref48Sel(ref48Sel),
		.clkCfgErr(clkCfgErr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr));

	sbocd_otp_model sbocd_otp_model_i (.clk(clk), .rst_n(rst_n), .otpReq(otpReq),
		.otpAddr(otpAddr), .otpAck(otpAck), .otpData(otpData), .byte0(b0), .byte1(b1),
		.ackDelay(dly));

	// ==========================================
	// clock, watchdog, otp monitor
	always #(CLK_PERIOD_NS / 2.0) clk = ~clk;

	always @(posedge clk) begin
		cyc++;
		if (otpReq && otpAck) begin
			seenAddr.push_back(otpAddr);
		end
		if (cyc == 20000) begin
			n_errors++;
			summarize();
		end
	end

	// ==========================================
	// tasks
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		// only the bench watchdog ends a wait for the slave
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdChk(input logic [APB_AW-1:0] a, input logic [31:0] exp, input string msg);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, a, 32'h0, rd, err);
		chk(rd, exp, msg);
		chk(err, 1'b0, msg);
	endtask

	// straps stay legal except where a case probes the clock error flag
	task automatic resetFor(input int n, input int i);
		rst_n  <= 1'b0;
		straps <= S[i];
		fuse   <= F[i];
		b0     <= B0[i];
		b1     <= B1[i];
		dly    <= D[i];
		seenAddr.delete();
		repeat (n) @(posedge clk);
		chk(dbgPortBlock, 1'b1, "block in reset");
		chk(cfgDone, 1'b0, "done in reset");
		rst_n <= 1'b1;
	endtask

	function automatic logic [12:0] expv(input logic [21:0] s, input logic f,
			input logic [7:0] x0, input logic [7:0] x1);
		logic act, auth, r24, r48;
		act = x1[B1_DBG_DIS] ? f : s[SP_SEC_BOOT];
		auth = act & x1[B1_AUTH];
		r24 = s[SP_REF_SPARE] & s[SP_REF_FREQ] & (s[SP_PLLSEL_LSB+:2] == PLLSEL_XTAL);
		r48 = ~s[SP_REF_SPARE] & ~s[SP_REF_FREQ] & (s[SP_PLLSEL_LSB+:2] == PLLSEL_XTAL);
		return {1'b1, act, act & x0[B0_DBG_BLOCK], act & x0[B0_SEC_WORLD],
			~(act & x1[B1_DBG_DIS]), auth, auth ? x1[B1_KEY_LSB+:2] : KEY_NA,
			auth & x1[B1_KEY_PKG], s[SP_PLL_EN], r24, r48, ~(r24 | r48)};
	endfunction

	task automatic boot(input int i);
		logic [12:0] e;
		logic [31:0] st;
		int          n;
		e = expv(S[i], F[i], B0[i], B1[i]);
		st = '0;
		st[STS_DONE] = e[12];
		st[STS_SEC_ACT] = e[11];
		st[STS_CLK_ERR] = e[0];
		st[STS_REF24] = e[2];
		st[STS_REF48] = e[1];
		st[STS_PLL_EN] = e[3];
		st[STS_DBG_BLOCK+:4] = {e[7], e[8], e[9], e[10]};
		st[STS_KEY_LSB+:3] = {e[4], e[6:5]};
		resetFor(400, i);
		n = 0;
		while (cfgDone !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		chk(32'(seenAddr.size()), 32'd2, "otp reads");
		chk({seenAddr[0], seenAddr[1]}, {OTP_BYTE0_ADDR, OTP_BYTE1_ADDR}, "otp order");
		chk(outv[12:4], e[12:4], "security");
		chk(outv[3:0], e[3:0], "clock");
		rdChk(ADDR_STATUS, st, "status");
		rdChk(ADDR_OTP, {16'h0, B1[i], B0[i]}, "otp copy");
		rdChk(ADDR_STRAP, {10'h0, S[i]}, "strap copy");
		straps <= ~S[i];
		fuse   <= ~F[i];
		repeat (20) @(posedge clk);
		chk(outv, e, "hold");
		chk(32'(seenAddr.size()), 32'd2, "no reread");
		$display("test %0d done", i);
	endtask

	// ==========================================
	// main sequence
	initial begin
		logic [31:0] r0;
		logic [31:0] rd;
		logic        err;
		resetFor(3, 0);
		// let the release stand one edge before the first boot pulls reset again
		@(posedge clk);
		for (int i = 0; i < 6; i++) begin
			boot(i);
		end
		apb(1'b0, ADDR_STATUS, 32'h0, r0, err);
		apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF, rd, err);
		chk(err, 1'b0, "ro write err");
		rdChk(ADDR_STATUS, r0, "ro write");
		apb(1'b0, 12'h010, 32'h0, rd, err);
		chk({rd[30:0], err}, 32'h1, "unmapped");
		apb(1'b1, ADDR_CTRL, 32'h1, rd, err);
		// the block output is registered from the write edge, so look one edge later
		@(posedge clk);
		chk(dbgPortBlock, 1'b1, "force block");
		apb(1'b1, ADDR_CTRL, 32'h0, rd, err);
		chk(dbgPortBlock, 1'b1, "force sticky");
		rdChk(ADDR_CTRL, 32'h1, "ctrl");
		$display("test apb done");
		summarize();
	end
endmodule
`default_nettype wire
